// file: mos_status_regs.sv
// mos_status_regs.sv - read-only output and status bank of the motion
// co-processor, read by the host through the serial register port.
// assumes: core data arrives on ref_clk with a one-cycle sampleValid
// strobe; the host read address arrives through the serial block, which
// sits on another clock, so it is synchronised here.
//
// Operation
// - velocity axes split low and high bytes
// - rate code 111 selects low-latency gyro
// - self-test results reuse the velocity pairs
// - signed temperature byte, resets to zero
// - bit 7 flags compass offset update
// - bit 6 flags rate offset update
// - bits 5..3 flag gyro z,y,x saturation
// - bits 2..1 flag accel z,y saturation
// - status two bits 5..3 field saturation
// - bits 2..0 velocity overflow; 7,6 zero
// - six velocity bytes from 0x35, x,y,z
`timescale 1ns/100ps
`include "mos_cfg.svh"
module mos_status_regs
   import mos_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // core side, same clock
   input  wire logic        sampleValid,
   input  wire logic [47:0] velIncIn,
   input  wire logic [47:0] lowLatencyIn,
   input  wire logic [47:0] selfTestIn,
   input  wire logic        selfTestActive,
   input  wire logic [2:0]  gyroRateSelect,
   input  wire logic [7:0]  temperatureIn,
   input  wire logic        compassOffsetUpdated,
   input  wire logic        rateOffsetUpdated,
   input  wire logic [2:0]  rateSaturated,
   input  wire logic [1:0]  accelSaturated,
   input  wire logic [2:0]  fieldSaturated,
   input  wire logic [2:0]  velOverflow,
   // host register port, from the serial interface domain
   input  wire logic [7:0]  hostAddr,
   output logic      [7:0]  hostRdata,
   output logic             hostHit,
   output logic             sampleBusy
);
   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   logic [47:0] resultMux;
   logic [7:0]  addrSync;
   logic        busyQual;

   logic [15:0] velX_reg, velX_next;
   logic [15:0] velY_reg, velY_next;
   logic [15:0] velZ_reg, velZ_next;
   logic [7:0]  temperature_reg, temperature_next;
   logic [7:0]  statusOne_reg, statusOne_next;
   logic [7:0]  statusTwo_reg, statusTwo_next;
   logic [7:0]  rdata_reg, rdata_next;
   logic [7:0]  addrHeld_reg, addrHeld_next;
   logic        hit_reg, hit_next;
   mos_state_t  state_reg, state_next;

   // splits a 16-bit word into the byte the host asked for
   function automatic logic [7:0] pick_byte(input logic [15:0] w,
                                            input logic hi);
      pick_byte = hi ? w[15:8] : w[7:0];
   endfunction

   // ------------------------------------------------------------------
   // submodules
   // ------------------------------------------------------------------
   // address comes from the serial engine's clock; two flops first
   mos_in_sync #(.WIDTH(8)) u_mos_in_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .asyncIn (hostAddr),
      .syncOut (addrSync)
   );

   mos_source_mux u_mos_source_mux (
      .gyroRateSelect (gyroRateSelect),
      .selfTestActive (selfTestActive),
      .velIncIn       (velIncIn),
      .lowLatencyIn   (lowLatencyIn),
      .selfTestIn     (selfTestIn),
      .srcSel         (),
      .resultOut      (resultMux)
   );

   // ------------------------------------------------------------------
   // sample capture
   // ------------------------------------------------------------------
   // every field is rewritten on a sample, so stale flags never linger;
   // flags are not sticky across periods by design
   always_comb begin
      velX_next        = velX_reg;
      velY_next        = velY_reg;
      velZ_next        = velZ_reg;
      temperature_next = temperature_reg;
      statusOne_next   = statusOne_reg;
      statusTwo_next   = statusTwo_reg;
      if (sampleValid) begin
         velX_next        = resultMux[15:0];
         velY_next        = resultMux[31:16];
         velZ_next        = resultMux[47:32];
         temperature_next = temperatureIn;
         statusOne_next   = 8'h00;
         statusOne_next[`MOS_S1_COMPASS_UPD] = compassOffsetUpdated;
         statusOne_next[`MOS_S1_RATE_UPD]    = rateOffsetUpdated;
         statusOne_next[`MOS_S1_RATE_Z_SAT]  = rateSaturated[2];
         statusOne_next[`MOS_S1_RATE_Y_SAT]  = rateSaturated[1];
         statusOne_next[`MOS_S1_RATE_X_SAT]  = rateSaturated[0];
         statusOne_next[`MOS_S1_ACCEL_Z_SAT] = accelSaturated[1];
         statusOne_next[`MOS_S1_ACCEL_Y_SAT] = accelSaturated[0];
         statusTwo_next   = 8'h00;
         statusTwo_next[`MOS_S2_FIELD_Z_SAT] = fieldSaturated[2];
         statusTwo_next[`MOS_S2_FIELD_Y_SAT] = fieldSaturated[1];
         statusTwo_next[`MOS_S2_FIELD_X_SAT] = fieldSaturated[0];
         statusTwo_next[`MOS_S2_VEL_Z_OVF]   = velOverflow[2];
         statusTwo_next[`MOS_S2_VEL_Y_OVF]   = velOverflow[1];
         statusTwo_next[`MOS_S2_VEL_X_OVF]   = velOverflow[0];
      end
   end

   // all result registers clear on reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         velX_reg        <= `MOS_RST_WORD;
         velY_reg        <= `MOS_RST_WORD;
         velZ_reg        <= `MOS_RST_WORD;
         temperature_reg <= `MOS_RST_BYTE;
         statusOne_reg   <= `MOS_RST_BYTE;
         statusTwo_reg   <= `MOS_RST_BYTE;
      end else begin
         velX_reg        <= velX_next;
         velY_reg        <= velY_next;
         velZ_reg        <= velZ_next;
         temperature_reg <= temperature_next;
         statusOne_reg   <= statusOne_next;
         statusTwo_reg   <= statusTwo_next;
      end
   end

   // ------------------------------------------------------------------
   // update marker
   // ------------------------------------------------------------------
   // busy for the cycle after a capture so the host side can tell a
   // read may straddle an update; a coherent pair needs no extra shadow
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         MOS_ST_IDLE: begin
            if (sampleValid) begin
               state_next = MOS_ST_HOLD;
            end
         end
         MOS_ST_HOLD: begin
            if (!sampleValid) begin
               state_next = MOS_ST_IDLE;
            end
         end
         default: begin
            state_next = MOS_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_reg <= MOS_ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   assign busyQual   = (state_reg == MOS_ST_HOLD);
   assign sampleBusy = busyQual;

   // ------------------------------------------------------------------
   // host read decode
   // ------------------------------------------------------------------
   // unmapped addresses return zero with the hit flag low; the address
   // bits cross clocks one by one, so a skewed mix could decode another
   // register for a cycle: data only follows an address seen twice
   always_comb begin
      addrHeld_next = addrSync;
      rdata_next = 8'h00;
      hit_next   = 1'b1;
      unique case (addrSync)
         `MOS_OFF_VEL_X_LOW:   rdata_next = pick_byte(velX_reg, 1'b0);
         `MOS_OFF_VEL_X_HIGH:  rdata_next = pick_byte(velX_reg, 1'b1);
         `MOS_OFF_VEL_Y_LOW:   rdata_next = pick_byte(velY_reg, 1'b0);
         `MOS_OFF_VEL_Y_HIGH:  rdata_next = pick_byte(velY_reg, 1'b1);
         `MOS_OFF_VEL_Z_LOW:   rdata_next = pick_byte(velZ_reg, 1'b0);
         `MOS_OFF_VEL_Z_HIGH:  rdata_next = pick_byte(velZ_reg, 1'b1);
         `MOS_OFF_TEMPERATURE: rdata_next = temperature_reg;
         `MOS_OFF_STATUS_ONE:  rdata_next = statusOne_reg;
         `MOS_OFF_STATUS_TWO:  rdata_next = statusTwo_reg;
         default: begin
            hit_next = 1'b0;
         end
      endcase
      if (addrSync != addrHeld_reg) begin
         rdata_next = rdata_reg;                          // hold old
         hit_next   = hit_reg;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata_reg    <= `MOS_RST_BYTE;
         hit_reg      <= 1'b0;
         addrHeld_reg <= `MOS_RST_BYTE;
      end else begin
         rdata_reg    <= rdata_next;
         hit_reg      <= hit_next;
         addrHeld_reg <= addrHeld_next;
      end
   end

   assign hostRdata = rdata_reg;
   assign hostHit   = hit_reg;
endmodule

// file: mos_cfg.svh
// mos_cfg.svh - offsets, field positions, reset values and codes for the
// motion output status register bank.
// assumes: included by mos_status_regs and mos_source_mux by bare name.
`ifndef MOS_CFG_SVH
`define MOS_CFG_SVH

// ---------------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------------
`define MOS_OFF_VEL_X_LOW      8'h35
`define MOS_OFF_VEL_X_HIGH     8'h36
`define MOS_OFF_VEL_Y_LOW      8'h37
`define MOS_OFF_VEL_Y_HIGH     8'h38
`define MOS_OFF_VEL_Z_LOW      8'h39
`define MOS_OFF_VEL_Z_HIGH     8'h3A
`define MOS_OFF_TEMPERATURE    8'h3B
`define MOS_OFF_STATUS_ONE     8'h3C
`define MOS_OFF_STATUS_TWO     8'h3D

// ---------------------------------------------------------------------
// reset values
// ---------------------------------------------------------------------
`define MOS_RST_BYTE           8'h00
`define MOS_RST_WORD           16'h0000

// ---------------------------------------------------------------------
// status one fields
// ---------------------------------------------------------------------
`define MOS_S1_COMPASS_UPD     7
`define MOS_S1_RATE_UPD        6
`define MOS_S1_RATE_Z_SAT      5
`define MOS_S1_RATE_Y_SAT      4
`define MOS_S1_RATE_X_SAT      3
`define MOS_S1_ACCEL_Z_SAT     2
`define MOS_S1_ACCEL_Y_SAT     1

// ---------------------------------------------------------------------
// status two fields
// ---------------------------------------------------------------------
`define MOS_S2_FIELD_Z_SAT     5
`define MOS_S2_FIELD_Y_SAT     4
`define MOS_S2_FIELD_X_SAT     3
`define MOS_S2_VEL_Z_OVF       2
`define MOS_S2_VEL_Y_OVF       1
`define MOS_S2_VEL_X_OVF       0

// ---------------------------------------------------------------------
// gyro rate code selecting low-latency stabilise data
// ---------------------------------------------------------------------
`define MOS_RATE_LOW_LATENCY   3'h7

`endif

// file: mos_pkg.sv
// mos_pkg.sv - types for the motion output status register bank.
// assumes: mos_cfg.svh holds the register numbers; state and source encodings are here.
package mos_pkg;
   // source feeding the three 16-bit result pairs
   typedef enum logic [2:0] {
      MOS_SRC_VEL      = 3'b001,
      MOS_SRC_LOWLAT   = 3'b010,
      MOS_SRC_SELFTEST = 3'b100
   } mos_src_t;

   // capture sequencing state
   typedef enum logic [1:0] {
      MOS_ST_IDLE = 2'b01,
      MOS_ST_HOLD = 2'b10
   } mos_state_t;
endpackage

// file: mos_in_sync.sv
// mos_in_sync.sv - two-flop synchroniser for a bus of levels.
// assumes: inputs come from outside the ref_clk domain.
`timescale 1ns/100ps
module mos_in_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;

   // first stage is read only by the second
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
      end else begin
         stage1_reg <= asyncIn;
         stage2_reg <= stage1_reg;
      end
   end

   assign syncOut = stage2_reg;
endmodule

// file: mos_source_mux.sv
// mos_source_mux.sv - picks which 16-bit triple feeds the result pairs.
// assumes: all inputs are on ref_clk; output is combinational.
`timescale 1ns/100ps
`include "mos_cfg.svh"
module mos_source_mux
   import mos_pkg::*;
(
   input  wire logic [2:0]  gyroRateSelect,
   input  wire logic        selfTestActive,
   input  wire logic [47:0] velIncIn,
   input  wire logic [47:0] lowLatencyIn,
   input  wire logic [47:0] selfTestIn,
   output mos_src_t         srcSel,
   output logic      [47:0] resultOut
);
   // self-test wins: its results must not be overwritten by stream data
   always_comb begin
      if (selfTestActive) begin
         srcSel    = MOS_SRC_SELFTEST;
         resultOut = selfTestIn;
      end else if (gyroRateSelect == `MOS_RATE_LOW_LATENCY) begin
         srcSel    = MOS_SRC_LOWLAT;
         resultOut = lowLatencyIn;
      end else begin
         srcSel    = MOS_SRC_VEL;
         resultOut = velIncIn;
      end
   end
endmodule

// file: mos_status_props.sv
// mos_status_props.sv - port-level checker for the status register bank.
// assumes: bound to mos_status_regs; reads hold the address >= 4 edges.
`timescale 1ns/100ps
module mos_status_props (
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        sampleValid,
   input wire logic [47:0] velIncIn,
   input wire logic [47:0] lowLatencyIn,
   input wire logic [47:0] selfTestIn,
   input wire logic        selfTestActive,
   input wire logic [2:0]  gyroRateSelect,
   input wire logic        compassOffsetUpdated,
   input wire logic        rateOffsetUpdated,
   input wire logic [2:0]  rateSaturated,
   input wire logic [1:0]  accelSaturated,
   input wire logic [2:0]  fieldSaturated,
   input wire logic [2:0]  velOverflow,
   input wire logic [7:0]  hostAddr,
   input wire logic [7:0]  hostRdata,
   input wire logic        hostHit,
   input wire logic        sampleBusy
);
   // ----------------------------------------
   // expected bytes, taken apart before $past
   // ----------------------------------------
   wire logic [7:0] velLo = velIncIn[7:0];
   wire logic [7:0] lowHi = lowLatencyIn[47:40];
   wire logic [7:0] stYLo = selfTestIn[23:16];
   wire logic [7:0] expOne = {compassOffsetUpdated, rateOffsetUpdated,
                              rateSaturated, accelSaturated, 1'b0};
   wire logic [7:0] expTwo = {2'b00, fieldSaturated, velOverflow};
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // address held long enough to cross the synchroniser
   sequence s_addr;
      $stable(hostAddr) [*4];
   endsequence
   // quiet cycles after a capture, address unchanged
   sequence s_hold;
      (!sampleValid && $stable(hostAddr)) [*4];
   endsequence
   property p_busy;
      sampleValid ##1 !sampleValid |-> sampleBusy ##1 !sampleBusy;
   endproperty
   property p_miss;
      s_addr ##0 !(hostAddr inside {[8'h35:8'h3D]})
         |-> hostRdata == 8'h00 && !hostHit;
   endproperty
   property p_hit;
      s_addr ##0 (hostAddr inside {[8'h35:8'h3D]}) |-> hostHit;
   endproperty
   property p_vel;
      (sampleValid && !selfTestActive && gyroRateSelect != 3'h7 &&
       hostAddr == 8'h35) ##1 s_hold |-> hostRdata == $past(velLo, 4);
   endproperty
   property p_low;
      (sampleValid && !selfTestActive && gyroRateSelect == 3'h7 &&
       hostAddr == 8'h3A) ##1 s_hold |-> hostRdata == $past(lowHi, 4);
   endproperty
   property p_self;
      (sampleValid && selfTestActive && hostAddr == 8'h37) ##1 s_hold
         |-> hostRdata == $past(stYLo, 4);
   endproperty
   property p_stat1;
      (sampleValid && hostAddr == 8'h3C) ##1 s_hold
         |-> hostRdata == $past(expOne, 4);
   endproperty
   property p_stat2;
      (sampleValid && hostAddr == 8'h3D) ##1 s_hold
         |-> hostRdata == $past(expTwo, 4);
   endproperty
   a_busy: assert property (p_busy) else $error("busy flag wrong");
   a_miss: assert property (p_miss) else $error("unmapped read");
   a_hit: assert property (p_hit) else $error("mapped miss");
   a_vel: assert property (p_vel) else $error("vel x low");
   a_low: assert property (p_low) else $error("low latency");
   a_self: assert property (p_self) else $error("self test");
   a_stat1: assert property (p_stat1) else $error("status one");
   a_stat2: assert property (p_stat2) else $error("status two");
endmodule
bind mos_status_regs mos_status_props u_mos_status_props (
   .ref_clk, .rst, .sampleValid, .velIncIn, .lowLatencyIn, .selfTestIn,
   .selfTestActive, .gyroRateSelect, .compassOffsetUpdated,
   .rateOffsetUpdated, .rateSaturated, .accelSaturated, .fieldSaturated,
   .velOverflow, .hostAddr, .hostRdata, .hostHit, .sampleBusy);

// file: mos_host_model.sv
// mos_host_model.sv - host reader behind the serial register port.
// assumes: one read at a time; address held until data is taken.
`timescale 1ns/100ps
module mos_host_model (
   input  wire logic       ref_clk,
   output logic      [7:0] hostAddr,
   input  wire logic [7:0] hostRdata,
   input  wire logic       hostHit
);
   // ----------------------------------------
   // read access
   // ----------------------------------------
   initial hostAddr = 8'h00;
   // park the address so a capture is seen in place
   task automatic park(input logic [7:0] a);
      @(posedge ref_clk);
      #1 hostAddr = a;
   endtask
   // two edges to cross, one to confirm the address, one to load data
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic h);
      park(a);
      repeat (4) @(posedge ref_clk);
      #1 d = hostRdata;
      h = hostHit;
   endtask
endmodule

// file: mos_status_regs_bench.sv
// mos_status_regs_bench.sv - directed checks of the status bank.
// assumes: host reads go through mos_host_model, core side driven here.
`timescale 1ns/100ps
module mos_status_regs_bench;
   // ----------------------------------------
   // stimulus and checking
   // ----------------------------------------
   logic        ref_clk, rst, sampleValid, selfTestActive, hostHit, h;
   logic        compassOffsetUpdated, rateOffsetUpdated, sampleBusy;
   logic [1:0]  accelSaturated;
   logic [2:0]  gyroRateSelect, rateSaturated, fieldSaturated, velOverflow;
   logic [7:0]  temperatureIn, hostAddr, hostRdata, d;
   logic [47:0] velIncIn, lowLatencyIn, selfTestIn;
   int          err_total = 0, tests_run = 0;
   mos_status_regs u_mos_status_regs (.ref_clk, .rst, .sampleValid,
      .velIncIn, .lowLatencyIn, .selfTestIn, .selfTestActive,
      .gyroRateSelect, .temperatureIn, .compassOffsetUpdated,
      .rateOffsetUpdated, .rateSaturated, .accelSaturated,
      .fieldSaturated, .velOverflow, .hostAddr, .hostRdata, .hostHit,
      .sampleBusy);
   mos_host_model u_mos_host_model (.ref_clk, .hostAddr, .hostRdata,
      .hostHit);
   always #20 ref_clk = ~ref_clk;
   task automatic chk(input string n, input logic [7:0] e, g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, e, input logic eh);
      u_mos_host_model.rd(a, d, h);
      chk($sformatf("rdata %h", a), e, d);
      chk($sformatf("hit %h", a), {7'h00, eh}, {7'h00, h});
   endtask
   // six bytes, low byte first, x then y then z
   task automatic rd6(input logic [47:0] w);
      for (int i = 0; i < 6; i++)
         rdchk(8'(8'h35 + i), w[8*i +: 8], 1'b1);
   endtask
   task automatic cap();
      @(posedge ref_clk);
      #1 sampleValid = 1'b1;
      @(posedge ref_clk);
      #1 sampleValid = 1'b0;
   endtask
   task automatic fl(input logic [12:0] v);
      {compassOffsetUpdated, rateOffsetUpdated, rateSaturated,
       accelSaturated, fieldSaturated, velOverflow} = v;
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // hang guard, far beyond the directed sequence
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_total++;
      results();
   end
   // main sequence
   initial begin
      ref_clk = 1'b0;
      rst = 1'b1;
      {sampleValid, selfTestActive, gyroRateSelect, temperatureIn} = '0;
      {velIncIn, lowLatencyIn, selfTestIn} = '0;
      fl(13'h0000);
      repeat (8) @(posedge ref_clk);
      #1 rst = 1'b0;
      for (int i = 8'h34; i <= 8'h3E; i++)
         rdchk(8'(i), 8'h00, i inside {[8'h35:8'h3D]});
      $display("done: reset values and map");
      velIncIn = 48'h8001_7FFF_C3A4;
      lowLatencyIn = 48'h1122_3344_5566;
      selfTestIn = 48'h5AA5_A55A_0FF0;
      gyroRateSelect = 3'h6;
      u_mos_host_model.park(8'h35);
      cap();
      rd6(velIncIn);
      gyroRateSelect = 3'h7;
      cap();
      rdchk(8'h3A, lowLatencyIn[47:40], 1'b1);
      rd6(lowLatencyIn);
      selfTestActive = 1'b1;
      u_mos_host_model.park(8'h37);
      cap();
      rdchk(8'h37, selfTestIn[23:16], 1'b1);
      rd6(selfTestIn);
      $display("done: result pairs");
      {selfTestActive, gyroRateSelect} = '0;
      temperatureIn = 8'hF6;
      cap();
      chk("busy", 8'h01, {7'h00, sampleBusy});
      rdchk(8'h3B, 8'hF6, 1'b1);
      chk("busy idle", 8'h00, {7'h00, sampleBusy});
      // two patterns that between them set and clear every flag bit
      for (int k = 0; k < 2; k++) begin
         u_mos_host_model.park(k ? 8'h3D : 8'h3C);
         fl(k ? 13'h0D9E : 13'h1261);
         cap();
         // read the parked byte first so the checker sees it undisturbed
         if (k)
            rdchk(8'h3D, {2'b00, fieldSaturated, velOverflow},
               1'b1);
         rdchk(8'h3C, {compassOffsetUpdated,
            rateOffsetUpdated, rateSaturated, accelSaturated,
            1'b0}, 1'b1);
         rdchk(8'h3D, {2'b00, fieldSaturated, velOverflow},
            1'b1);
      end
      $display("done: status flags");
      // reset mid-run clears captured data and flags
      @(posedge ref_clk);
      #1 rst = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1 rst = 1'b0;
      rdchk(8'h3C, 8'h00, 1'b1);
      rdchk(8'h35, 8'h00, 1'b1);
      // back-to-back samples: only the latest one shows
      fl(13'h1FFF);
      @(posedge ref_clk);
      #1 sampleValid = 1'b1;
      @(posedge ref_clk);
      #1 fl(13'h0000);
      @(posedge ref_clk);
      #1 sampleValid = 1'b0;
      rdchk(8'h3C, 8'h00, 1'b1);
      rdchk(8'h3D, 8'h00, 1'b1);
      $display("done: reset and refresh");
      results();
   end
endmodule
